// ==== trace_view_pkg.sv ====
// Package: constants and carriers for the trace view and timestamp front logic
package trace_view_pkg;

	localparam int unsigned CLK_FREQ_HZ      = 25000000;

	// Address decode of the stimulus window
	localparam int unsigned ADDR_W           = 40;
	localparam int unsigned WINDOW_BITS      = 24;
	localparam logic [39:0] WINDOW_BASE      = 40'h00_0000_0000;
	localparam int unsigned PORT_BITS        = 16;
	localparam int unsigned PORT_LSB         = 8;
	localparam int unsigned DATA_W           = 64;

	// Views and master numbering
	localparam int unsigned VIEW_COUNT       = 64;
	localparam logic [5:0]  VIEW_BIG_LO      = 6'h00;
	localparam logic [5:0]  VIEW_BIG_HI      = 6'h01;
	localparam logic [5:0]  VIEW_LITTLE_LO   = 6'h04;
	localparam logic [5:0]  VIEW_LITTLE_HI   = 6'h07;
	localparam logic [5:0]  VIEW_GPU         = 6'h20;
	localparam logic [5:0]  VIEW_SCP         = 6'h21;
	localparam logic [5:0]  VIEW_EXP_BASE    = 6'h22;
	localparam logic [5:0]  VIEW_DEFAULT     = 6'h3e;
	localparam logic [5:0]  VIEW_DEBUG       = 6'h3f;
	localparam logic [6:0]  NONSECURE_OFFSET = 7'h40;
	localparam logic [3:0]  EXP_SEL_MIN      = 4'h1;
	localparam logic [3:0]  EXP_SEL_MAX      = 4'h8;

	// Hardware events
	localparam int unsigned HW_EVENT_W       = 64;
	localparam int unsigned TRIG_W           = 8;
	localparam int unsigned TRIG_A           = 4;
	localparam int unsigned TRIG_B           = 5;
	// Synchroniser rest value: triggers low, inverted copies high
	localparam logic [3:0]  EV_IDLE          = 4'ha;

	// Timestamp layout
	localparam int unsigned TS_W             = 64;
	localparam int unsigned TS_COUNT_W       = 56;
	localparam int unsigned TS_INTERP_W      = 8;

	// Stimulus FIFO
	localparam int unsigned FIFO_DEPTH       = 8;

	typedef enum logic [2:0] {
		SRC_BIG    = 3'h0,
		SRC_LITTLE = 3'h1,
		SRC_GPU    = 3'h2,
		SRC_SCP    = 3'h3,
		SRC_EXP    = 3'h4,
		SRC_DEBUG  = 3'h5,
		SRC_OTHER  = 3'h6
	} master_class_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              nonsecure;
		master_class_type  src;
		logic [1:0]        core;
		logic [3:0]        user_sel;
	} stim_write_type;

	typedef struct packed {
		logic [6:0]           master_id;
		logic [PORT_BITS-1:0] port;
		logic [DATA_W-1:0]    data;
		logic [TS_W-1:0]      timestamp;
	} trace_packet_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

endpackage

// ==== stim_fifo.sv ====
// Stimulus packet FIFO with valid/ready on both sides
`timescale 1ns/100ps
module stim_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ==== trace_view_front.sv ====
// Trace source front logic: stimulus views, master IDs, hardware events, timestamp
`timescale 1ns/100ps
// Summary of operation
// - A write hitting the 16MB stimulus window goes to the private view of its master.
// - Each view spans the whole 65536-port stimulus range, taken from the address bits.
// - Sixty-four views exist, some reserved, each mapped to a master ID on the trace output.
// - The expansion port drives the user field with x+1 to select expansion view x, x in 0..7.
// - A user field outside 1..8 from no known master selects default view 62.
// - Master ID is the view for secure writes and the view plus 64 for non-secure writes.
// - Views: 0-1 big, 4-7 little, 32 GPU, 33 SCP, 34-41 expansion, 62 default, 63 debug.
// - A rising edge on any of hardware event inputs 0-3 produces a trace event.
// - Events 0 and 2 follow trigger outputs 4 and 5, events 1 and 3 inverted; 4-63 reserved.
// - Timestamp upper 56 bits are the reference count, low 8 bits are interpolated.
// - The timestamp is plain binary and 64 bits wide.
// - A dedicated timestamp counter runs on the reference tick and serves only trace.
// - A separate configuration port stands apart from the stimulus write port.
module trace_view_front
	import trace_view_pkg::*;
(
	input  wire logic                                  clk_sys,
	input  wire logic                                  rstn,
	input  wire logic                                  stim_valid,
	output logic                                       stim_ready,
	input  wire trace_view_pkg::stim_write_type        stim_req,
	input  wire logic                                  pkt_ready,
	output logic                                       pkt_valid,
	output trace_view_pkg::trace_packet_type           pkt_out,
	input  wire logic [trace_view_pkg::TRIG_W-1:0]     cross_trigger_outputs,
	output logic [trace_view_pkg::HW_EVENT_W-1:0]      hw_event_pulse_q,
	input  wire logic                                  always_on_ref_clock,
	output logic [trace_view_pkg::TS_W-1:0]            timestamp_q,
	input  wire trace_view_pkg::apb_req_type           cfg_apb,
	output logic                                       cfg_pready_q,
	output logic [31:0]                                cfg_prdata_q,
	output logic                                       trace_enable_q
);
	import trace_view_pkg::*;

	// ----------------------------------------
	// View selection
	// ----------------------------------------
	logic                 hit;
	logic [5:0]           view;
	logic                 view_ok;
	logic [3:0]           exp_idx;

	assign hit = (stim_req.addr[ADDR_W-1:WINDOW_BITS] == WINDOW_BASE[ADDR_W-1:WINDOW_BITS]);

	always_comb begin
		exp_idx = stim_req.user_sel - EXP_SEL_MIN;
		view    = VIEW_DEFAULT;
		view_ok = 1'b1;
		case (stim_req.src)
			SRC_BIG: begin
				view = VIEW_BIG_LO + {5'h00, stim_req.core[0]};
			end
			SRC_LITTLE: begin
				view = VIEW_LITTLE_LO + {4'h0, stim_req.core};
			end
			SRC_GPU: begin
				view = VIEW_GPU;
			end
			SRC_SCP: begin
				view = VIEW_SCP;
			end
			SRC_DEBUG: begin
				view = VIEW_DEBUG;
			end
			SRC_EXP, SRC_OTHER: begin
				if (stim_req.user_sel >= EXP_SEL_MIN && stim_req.user_sel <= EXP_SEL_MAX) begin
					view = VIEW_EXP_BASE + {3'h0, exp_idx[2:0]};
				end else begin
					view = VIEW_DEFAULT;
				end
			end
			default: begin
				view    = VIEW_DEFAULT;
				view_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Master ID and packet forming
	// ----------------------------------------
	trace_packet_type pkt_d;
	logic             fifo_in_ready;
	logic             fifo_out_valid;
	trace_packet_type fifo_out;
	logic             stim_take;

	always_comb begin
		pkt_d           = '0;
		pkt_d.master_id = stim_req.nonsecure ? ({1'b0, view} + NONSECURE_OFFSET)
		                                     : {1'b0, view};
		pkt_d.port      = stim_req.addr[PORT_LSB +: PORT_BITS];
		pkt_d.data      = stim_req.data;
		pkt_d.timestamp = timestamp_q;
	end

	// Writes outside the window or while disabled are accepted and dropped
	assign stim_ready = fifo_in_ready;
	assign stim_take  = stim_valid && hit && view_ok && trace_enable_q;

	stim_fifo #(
		.WIDTH ($bits(trace_packet_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (stim_take),
		.in_ready  (fifo_in_ready),
		.in_data   (pkt_d),
		.out_valid (fifo_out_valid),
		.out_ready (pkt_ready || !pkt_valid),
		.out_data  (fifo_out)
	);

	// Output register keeps the packet port straight from flops
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pkt_valid <= 1'b0;
			pkt_out   <= '0;
		end else if (pkt_ready || !pkt_valid) begin
			pkt_valid <= fifo_out_valid;
			pkt_out   <= fifo_out;
		end
	end

	// ----------------------------------------
	// Hardware events
	// ----------------------------------------
	logic [3:0] ev_raw;
	logic [3:0] ev_s1_q;
	logic [3:0] ev_s2_q;
	logic [3:0] ev_s3_q;
	logic [3:0] ev_level_q;

	assign ev_raw = {~cross_trigger_outputs[TRIG_B], cross_trigger_outputs[TRIG_B],
	                 ~cross_trigger_outputs[TRIG_A], cross_trigger_outputs[TRIG_A]};

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ev_s1_q <= EV_IDLE;
			ev_s2_q <= EV_IDLE;
			ev_s3_q <= EV_IDLE;
		end else begin
			ev_s1_q <= ev_raw;
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
		end
	end

	// Level only moves when two stages agree; filters one-cycle glitches
	logic [3:0] ev_agree;
	logic [3:0] ev_fire;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ev
			assign ev_agree[gi] = (ev_s2_q[gi] == ev_s3_q[gi]);
			assign ev_fire[gi]  = ev_agree[gi] && ev_s3_q[gi] && !ev_level_q[gi];
		end
	endgenerate

	// Idle pattern at reset, so inverted inputs give no false edge
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ev_level_q       <= EV_IDLE;
			hw_event_pulse_q <= '0;
		end else begin
			ev_level_q       <= (ev_agree & ev_s3_q) | (~ev_agree & ev_level_q);
			hw_event_pulse_q <= HW_EVENT_W'(ev_fire & {4{trace_enable_q}});
		end
	end

	// ----------------------------------------
	// Timestamp
	// ----------------------------------------
	logic                   ref_s1_q;
	logic                   ref_s2_q;
	logic                   ref_s3_q;
	logic                   ref_lvl_q;
	logic                   ref_tick;
	logic [TS_COUNT_W-1:0]  ts_count_q;
	logic [TS_INTERP_W-1:0] interp_q;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ref_s1_q  <= 1'b0;
			ref_s2_q  <= 1'b0;
			ref_s3_q  <= 1'b0;
			ref_lvl_q <= 1'b0;
		end else begin
			ref_s1_q <= always_on_ref_clock;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
			if (ref_s2_q == ref_s3_q) begin
				ref_lvl_q <= ref_s3_q;
			end
		end
	end

	assign ref_tick = (ref_s2_q == ref_s3_q) && ref_s3_q && !ref_lvl_q;

	// Dedicated counter, never shared with processor timers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ts_count_q <= '0;
		end else if (ref_tick) begin
			ts_count_q <= ts_count_q + 1'b1;
		end
	end

	// Interpolator saturates so the value never runs past the next tick
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			interp_q <= '0;
		end else if (ref_tick) begin
			interp_q <= '0;
		end else if (interp_q != '1) begin
			interp_q <= interp_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			timestamp_q <= '0;
		end else begin
			timestamp_q <= {ts_count_q, interp_q};
		end
	end

	// ----------------------------------------
	// Configuration port
	// ----------------------------------------
	logic cfg_access;

	assign cfg_access = cfg_apb.psel && cfg_apb.penable && !cfg_pready_q;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cfg_pready_q   <= 1'b0;
			cfg_prdata_q   <= 32'h0000_0000;
			trace_enable_q <= 1'b1;
		end else begin
			cfg_pready_q <= cfg_access;
			cfg_prdata_q <= {31'h0000_0000, trace_enable_q};
			if (cfg_access && cfg_apb.pwrite) begin
				trace_enable_q <= cfg_apb.pwdata[0];
			end
		end
	end
endmodule

// ==== trace_view_front_asserts.sv ====
// Port checker for the trace view front logic
`timescale 1ns/100ps
module trace_view_front_asserts
	import trace_view_pkg::*;
(
	input wire logic                             clk_sys,
	input wire logic                             rstn,
	input wire logic                             stim_valid,
	input wire logic                             stim_ready,
	input wire trace_view_pkg::stim_write_type   stim_req,
	input wire logic                             pkt_ready,
	input wire logic                             pkt_valid,
	input wire trace_view_pkg::trace_packet_type pkt_out,
	input wire logic [7:0]                       cross_trigger_outputs,
	input wire logic [63:0]                      hw_event_pulse_q,
	input wire logic [63:0]                      timestamp_q,
	input wire trace_view_pkg::apb_req_type      cfg_apb,
	input wire logic                             cfg_pready_q,
	input wire logic                             trace_enable_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	wire [5:0] view = pkt_out.master_id[5:0];
	wire legal = view <= 6'h01 || (view >= 6'h04 && view <= 6'h29 && (view <= 6'h07 || view >= 6'h20))
		|| view >= 6'h3e;
	sequence s_take;
		stim_valid && stim_ready && stim_req.addr[39:24] == 16'h0 && trace_enable_q
			&& stim_req.src <= SRC_OTHER && !pkt_valid && pkt_ready;
	endsequence
	sequence s_rise4;
		trace_enable_q && $rose(cross_trigger_outputs[4]) ##1 cross_trigger_outputs[4][*2];
	endsequence
	property p_pkt_lat; s_take |-> ##[1:3] pkt_valid; endproperty
	property p_pkt_hold; pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_out); endproperty
	property p_view_legal; pkt_valid |-> legal; endproperty
	property p_evt_resv; hw_event_pulse_q[63:4] == 60'h0; endproperty
	property p_evt_once;
		hw_event_pulse_q[3:0] != 4'h0 |=> (hw_event_pulse_q[3:0] & $past(hw_event_pulse_q[3:0])) == 4'h0;
	endproperty
	property p_evt_rise; s_rise4 |-> ##[0:4] hw_event_pulse_q[0]; endproperty
	property p_evt_fall;
		trace_enable_q && $fell(cross_trigger_outputs[4]) |-> ##[1:6] hw_event_pulse_q[1];
	endproperty
	property p_ts_step;
		$past(rstn) |-> timestamp_q[63:8] - $past(timestamp_q[63:8]) <= 56'h1;
	endproperty
	property p_ts_interp;
		$past(rstn, 2) && timestamp_q[63:8] == $past(timestamp_q[63:8]) && $past(timestamp_q[7:0]) != 8'hff
			|-> timestamp_q[7:0] == $past(timestamp_q[7:0]) + 8'h1;
	endproperty
	property p_cfg_ack;
		cfg_apb.psel && cfg_apb.penable && !cfg_pready_q |=> cfg_pready_q ##1 !cfg_pready_q;
	endproperty
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_pkt_lat: assert property (p_pkt_lat) else $error("write without packet");
	a_pkt_hold: assert property (p_pkt_hold) else $error("packet moved under stall");
	a_view_legal: assert property (p_view_legal) else $error("reserved view used");
	a_evt_resv: assert property (p_evt_resv) else $error("reserved event fired");
	a_evt_once: assert property (p_evt_once) else $error("event longer than one cycle");
	a_evt_rise: assert property (p_evt_rise) else $error("rise gave no event");
	a_evt_fall: assert property (p_evt_fall) else $error("fall gave no event");
	a_ts_step: assert property (p_ts_step) else $error("count jumped");
	a_ts_interp: assert property (p_ts_interp) else $error("low bits not counting");
	a_cfg_ack: assert property (p_cfg_ack) else $error("config not answered");
endmodule
bind trace_view_front trace_view_front_asserts chk_u (.clk_sys, .rstn, .stim_valid, .stim_ready,
	.stim_req, .pkt_ready, .pkt_valid, .pkt_out, .cross_trigger_outputs, .hw_event_pulse_q,
	.timestamp_q, .cfg_apb, .cfg_pready_q, .trace_enable_q);

// ==== stim_master_model.sv ====
// Write master model on the stimulus request port
`timescale 1ns/100ps
module stim_master_model
	import trace_view_pkg::*;
(
	input wire logic                           clk_sys,
	input wire logic                           rstn,
	input wire logic                           go,
	input wire trace_view_pkg::stim_write_type req,
	input wire logic                           stim_ready,
	output logic                               stim_valid,
	output trace_view_pkg::stim_write_type     stim_req,
	output logic                               done_q
);
	always_ff @(posedge clk_sys) begin
		done_q <= rstn && stim_valid && stim_ready;
		if (!rstn) begin
			stim_valid <= 1'b0;
		end else if (go) begin
			stim_valid <= 1'b1;
			stim_req <= req;
		end else if (stim_valid && stim_ready) begin
			stim_valid <= 1'b0;
			// Released lines carry junk, never the old request
			stim_req <= ~stim_req;
		end
	end
endmodule

// ==== trace_view_front_tb.sv ====
// Self-checking bench for the trace view front logic
`timescale 1ns/100ps
module trace_view_front_tb;
	import trace_view_pkg::*;
	typedef struct packed {
		master_class_type src;
		logic [1:0]       core;
		logic [3:0]       sel;
		logic             ns;
		logic [6:0]       mid;
	} row_type;
	logic             clk_sys, rstn, go, stim_valid, stim_ready, pkt_ready, pkt_valid, done_q;
	logic             ref_clk, cfg_pready_q, trace_enable_q;
	logic [7:0]       trig;
	logic [63:0]      ev_pulse, ts;
	logic [31:0]      rd;
	logic [55:0]      t0;
	stim_write_type   req, stim_req, r;
	trace_packet_type pkt;
	apb_req_type      apb;
	bit               ok;
	int               err_total, checks_done, n, i, ev_cnt [4];
	row_type          rows [12] = '{'{SRC_BIG, 2'h1, 4'h0, 1'b0, 7'h01},
		'{SRC_BIG, 2'h0, 4'h0, 1'b1, 7'h40}, '{SRC_LITTLE, 2'h3, 4'h0, 1'b0, 7'h07},
		'{SRC_LITTLE, 2'h0, 4'h0, 1'b1, 7'h44}, '{SRC_GPU, 2'h0, 4'h0, 1'b1, 7'h60},
		'{SRC_SCP, 2'h0, 4'h0, 1'b0, 7'h21}, '{SRC_EXP, 2'h0, 4'h1, 1'b0, 7'h22},
		'{SRC_EXP, 2'h0, 4'h8, 1'b1, 7'h69}, '{SRC_OTHER, 2'h0, 4'h0, 1'b0, 7'h3e},
		'{SRC_OTHER, 2'h0, 4'h9, 1'b1, 7'h7e}, '{SRC_DEBUG, 2'h0, 4'h0, 1'b1, 7'h7f},
		'{SRC_EXP, 2'h0, 4'hf, 1'b0, 7'h3e}};
	trace_view_front dut_u (.clk_sys(clk_sys), .rstn(rstn), .stim_valid(stim_valid),
		.stim_ready(stim_ready), .stim_req(stim_req), .pkt_ready(pkt_ready), .pkt_valid(pkt_valid),
		.pkt_out(pkt), .cross_trigger_outputs(trig), .hw_event_pulse_q(ev_pulse),
		.always_on_ref_clock(ref_clk), .timestamp_q(ts), .cfg_apb(apb), .cfg_pready_q(cfg_pready_q),
		.cfg_prdata_q(rd), .trace_enable_q(trace_enable_q));
	stim_master_model model_u (.clk_sys(clk_sys), .rstn(rstn), .go(go), .req(req),
		.stim_ready(stim_ready), .stim_valid(stim_valid), .stim_req(stim_req), .done_q(done_q));
	// ----------------------------------------
	// Clock, event tally, watchdog
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (rstn) for (int k = 0; k < 4; k++) ev_cnt[k] += ev_pulse[k];
	// Whole run is near 600 cycles; 50000 leaves ample slack
	initial begin
		#2000000;
		err_total++;
		summarize();
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic summarize();
		$display("Checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	task automatic send(input stim_write_type w, output bit done);
		@(posedge clk_sys);
		go <= 1'b1;
		req <= w;
		@(posedge clk_sys);
		go <= 1'b0;
		done = 0;
		for (int k = 0; k < 6 && !done; k++) begin
			@(negedge clk_sys);
			done = done_q;
		end
	endtask
	task automatic pkt_wait(output bit seen);
		seen = 0;
		for (int k = 0; k < 10 && !seen; k++) begin
			@(negedge clk_sys);
			seen = pkt_valid === 1'b1;
		end
	endtask
	task automatic cfg(input logic wr, input logic [31:0] d);
		@(posedge clk_sys);
		apb <= '{1'b1, 1'b0, wr, 12'h0, d};
		@(posedge clk_sys);
		apb.penable <= 1'b1;
		for (int k = 0; k < 8 && cfg_pready_q !== 1'b1; k++) @(negedge clk_sys);
		chk(cfg_pready_q, 1);
		@(posedge clk_sys);
		apb <= '0;
	endtask
	task automatic ev(input int b, input logic v, input int idx, input int e);
		int c0, s0;
		c0 = ev_cnt[idx];
		s0 = ev_cnt.sum();
		@(posedge clk_sys);
		trig[b] <= v;
		tick(10);
		@(negedge clk_sys);
		chk(ev_cnt[idx] - c0, e);
		chk(ev_cnt.sum() - s0, e);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		go = 1'b0;
		req = '0;
		pkt_ready = 1'b1;
		trig = 8'h00;
		ref_clk = 1'b0;
		apb = '0;
		tick(10);
		rstn <= 1'b1;
		for (i = 0; i < 12; i++) begin
			r = '{{16'h0, 16'hffff - 16'(i), 8'h0}, 64'(i), rows[i].ns, rows[i].src, rows[i].core,
				rows[i].sel};
			send(r, ok);
			pkt_wait(ok);
			chk(ok, 1);
			chk(pkt.master_id, rows[i].mid);
			chk(pkt.port, 16'hffff - 16'(i));
			chk(pkt.data, r.data);
		end
		r.addr = 40'h01_0000_0000;
		send(r, ok);
		pkt_wait(ok);
		chk(ok, 0);
		chk(ev_cnt.sum(), 0);
		r.addr = 40'h0;
		pkt_ready <= 1'b0;
		n = 0;
		ok = 1;
		while (ok && n < 20) begin
			r.data = 64'(n);
			send(r, ok);
			n += ok;
		end
		chk(n, FIFO_DEPTH + 1);
		@(posedge clk_sys);
		pkt_ready <= 1'b1;
		for (i = 0; i <= n; i++) begin
			pkt_wait(ok);
			chk(pkt.data, 64'(i));
		end
		ev(4, 1'b1, 0, 1);
		ev(4, 1'b0, 1, 1);
		ev(5, 1'b1, 2, 1);
		ev(5, 1'b0, 3, 1);
		ev(0, 1'b1, 0, 0);
		t0 = ts[63:8];
		repeat (5) begin
			@(posedge clk_sys);
			ref_clk <= 1'b1;
			tick(4);
			ref_clk <= 1'b0;
			tick(4);
		end
		tick(8);
		@(negedge clk_sys);
		chk(ts[63:8] - t0, 5);
		tick(300);
		@(negedge clk_sys);
		chk(ts[7:0], 8'hff);
		send(r, ok);
		pkt_wait(ok);
		chk(pkt.timestamp, {t0 + 56'h5, 8'hff});
		cfg(1'b1, 32'h0);
		cfg(1'b0, 32'h0);
		chk(rd[0], 0);
		chk(trace_enable_q, 0);
		send(r, ok);
		pkt_wait(ok);
		chk(ok, 0);
		ev(4, 1'b1, 0, 0);
		cfg(1'b1, 32'h1);
		@(posedge clk_sys);
		pkt_ready <= 1'b0;
		send(r, ok);
		pkt_wait(ok);
		chk(pkt_valid, 1);
		cfg(1'b1, 32'h0);
		@(posedge clk_sys);
		rstn <= 1'b0;
		tick(10);
		@(negedge clk_sys);
		chk(trace_enable_q, 1);
		chk(pkt_valid, 0);
		chk(ev_pulse, 0);
		chk(ts, 0);
		chk(stim_ready, 1);
		summarize();
	end
endmodule
